// >>> sfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  initial begin
    o_cs_n = 1'h1;
    o_sck = 1'h0;
    o_si = 1'h0;
  end
  // 16 system clocks a half period gives the 160 ns link clock
  task automatic tick;
    repeat (16) @(posedge i_clk);
  endtask
  task automatic run(input logic [63:0] h, input int nh, input int nr,
      output logic [63:0] rd);
    rd = 64'h0;
    @(posedge i_clk);
    o_sck <= h[63];
    tick();
    o_cs_n <= 1'h0;
    tick();
    for (int i = 0; i < nh; i++) begin
      o_sck <= 1'h0;
      o_si <= h[63 - i];
      tick();
      o_sck <= 1'h1;
      tick();
    end
    for (int i = 0; i < nr; i++) begin
      o_sck <= 1'h0;
      // don't-care input keeps moving so no stale level is trusted
      o_si <= ~o_si;
      tick();
      o_sck <= 1'h1;
      rd = {rd[62:0], i_so};
      tick();
    end
    o_sck <= h[63];
    tick();
    o_cs_n <= 1'h1;
    o_si <= ~o_si;
    tick();
  endtask
endmodule
`default_nettype wire

// >>> sfr_read_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_read_asserts #(parameter PAGE_BYTES = 264) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic [1:0] o_rd_src,
  input wire logic [11:0] o_rd_page,
  input wire logic [8:0] o_rd_byte,
  input wire logic [7:0] i_rd_data,
  input wire logic i_ready,
  input wire logic i_cmp_diff,
  input wire logic o_spi_mode,
  input wire logic o_cmd_active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic oe_q;
  always @(posedge i_clk) oe_q <= o_so_oe;
  deselect_float_a:
    assert property ($rose(i_cs_n) |-> ##[1:5] !o_so_oe)
    else $error("serial out driven after deselect");
  idle_float_a:
    assert property (i_cs_n [*7] |-> !o_so_oe)
    else $error("serial out driven while idle");
  launch_edge_a:
    assert property ($rose(o_so_oe) |-> o_cmd_active && !$past(i_sck, 2))
    else $error("serial out enabled off a clock fall");
  select_seen_a:
    assert property ($fell(i_cs_n) |-> ##[2:5] o_cmd_active)
    else $error("select not taken");
  shift_edge_a:
    assert property (o_so_oe && oe_q && $changed(o_so) |-> !$past(i_sck, 2))
    else $error("serial out moved off a clock fall");
  byte_step_a:
    assert property (o_so_oe && oe_q && $changed(o_rd_byte) |->
      o_rd_byte == ($past(o_rd_byte) == PAGE_BYTES - 1 ?
      9'h0 : $past(o_rd_byte) + 9'h1))
    else $error("byte address step wrong");
  page_step_a:
    assert property (o_so_oe && oe_q && $changed(o_rd_page) |->
      $past(o_rd_byte) == PAGE_BYTES - 1 &&
      o_rd_page == $past(o_rd_page) + 12'h1)
    else $error("page step wrong");
  source_hold_a:
    assert property (o_so_oe && oe_q |->
      $stable(o_spi_mode) && $stable(o_rd_src))
    else $error("source changed mid read");
  cover property (o_so_oe && o_rd_src == 2'h3);
  cover property (o_so_oe && oe_q && $changed(o_rd_page));
  cover property ($rose(i_cs_n) && o_so_oe);
endmodule
`default_nettype wire

// >>> sfr_read_path.v
// How it works
// - select low starts a command; 8-bit opcode then address decoded.
// - all opcode, address and data bits travel most significant bit first.
// - page_addr is 12 bits, page_byte_addr and buffer_byte_addr 9 bits.
// - opcodes 68h/E8h, 24 address bits, 32 dummy bits, then array data.
// - address: 3 reserved bits, 12-bit page_addr, 9-bit page_byte_addr.
// - continuous read steps every byte and crosses pages with no gap.
// - after the last array byte continuous read wraps to page zero.
// - chip select rising ends any read and floats serial out.
// - array reads never touch either buffer.
// - opcodes 52h/D2h, 24 address bits, 32 dummy bits, then page data.
// - page read wraps to the start of the same page.
// - 54h/D4h read buffer one, 56h/D6h read buffer two.
// - buffer read wraps from the last byte to byte zero.
// - 57h/D7h shift the status byte, bit 7 first, right after opcode.
// - upper six status bits carry information, lower two reserved.
// - status byte repeats while clocked, each time with fresh status.
// - the opcode variant selects the clock category of the read.
// - status bit 7 is one when ready, zero when busy.
// - status bit 6 is the latest compare result, one on mismatch.
// - status bits 5 to 2 hold a fixed density code.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_read_regs.vh"

module sfr_read_path #(
  parameter PAGE_BYTES = 264,
  parameter PAGE_AW = 12,
  parameter BYTE_AW = 9,
  // arbitrary value, no meaning beyond this model
  parameter [3:0] DENSITY_CODE = 4'h5
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_cs_n,
  input wire i_sck,
  input wire i_si,
  output reg o_so,
  output reg o_so_oe,
  output reg [1:0] o_rd_src,
  output reg [PAGE_AW-1:0] o_rd_page,
  output reg [BYTE_AW-1:0] o_rd_byte,
  input wire [7:0] i_rd_data,
  input wire i_ready,
  input wire i_cmp_diff,
  output reg o_spi_mode,
  output reg o_cmd_active
);

  localparam integer LAST_BYTE_I = PAGE_BYTES - 1;
  localparam [BYTE_AW-1:0] LAST_BYTE = LAST_BYTE_I[BYTE_AW-1:0];

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_OPC = 5'b00010;
  localparam [4:0] ST_HDR = 5'b00100;
  localparam [4:0] ST_DATA = 5'b01000;
  localparam [4:0] ST_IGN = 5'b10000;

  //////////////////////////////////////////////////////////////////////////////
  // opcode decode

  function [2:0] sfr_decode;
    input [7:0] op;
    begin
      if (op == `SFR_OP_CONT_A || op == `SFR_OP_CONT_B) begin
        sfr_decode = `SFR_K_CONT;
      end else if (op == `SFR_OP_PAGE_A || op == `SFR_OP_PAGE_B) begin
        sfr_decode = `SFR_K_PAGE;
      end else if (op == `SFR_OP_BUF1_A || op == `SFR_OP_BUF1_B) begin
        sfr_decode = `SFR_K_BUF1;
      end else if (op == `SFR_OP_BUF2_A || op == `SFR_OP_BUF2_B) begin
        sfr_decode = `SFR_K_BUF2;
      end else if (op == `SFR_OP_STAT_A || op == `SFR_OP_STAT_B) begin
        sfr_decode = `SFR_K_STAT;
      end else begin
        sfr_decode = `SFR_K_NONE;
      end
    end
  endfunction

  // read source behind each command kind
  function [1:0] sfr_src;
    input [2:0] kind;
    begin
      if (kind == `SFR_K_BUF1) begin
        sfr_src = `SFR_SRC_BUF1;
      end else if (kind == `SFR_K_BUF2) begin
        sfr_src = `SFR_SRC_BUF2;
      end else if (kind == `SFR_K_STAT) begin
        sfr_src = `SFR_SRC_STAT;
      end else begin
        // array reads bypass both buffers
        sfr_src = `SFR_SRC_ARRAY;
      end
    end
  endfunction

  // last header bit before data, counted from the first opcode bit
  function [6:0] sfr_hdr_last;
    input [2:0] kind;
    begin
      if (kind == `SFR_K_BUF1 || kind == `SFR_K_BUF2) begin
        sfr_hdr_last = `SFR_LAST_HDR_BUF;
      end else begin
        sfr_hdr_last = `SFR_LAST_HDR_ARRAY;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only feeds edge detection

  reg cs_s1_q;
  reg cs_s2_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg si_s1_q;
  reg si_s2_q;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= i_cs_n;
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= i_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q <= i_si;
      si_s2_q <= si_s1_q;
    end
  end

  wire sck_rise = sck_s2_q & ~sck_s3_q;
  wire sck_fall = ~sck_s2_q & sck_s3_q;

  //////////////////////////////////////////////////////////////////////////////
  // command state

  reg [4:0] state_q;
  reg [6:0] cnt_q;
  reg [23:0] hdr_q;
  reg [2:0] kind_q;
  reg [6:0] hdr_last_q;
  reg [2:0] bitn_q;
  reg [7:0] sh_q;

  wire [7:0] op_now = {hdr_q[6:0], si_s2_q};
  wire [2:0] kind_now = sfr_decode(op_now);
  wire [23:0] addr_now = {hdr_q[22:0], si_s2_q};

  // the status byte is built at each load so every repeat is current
  wire [7:0] stat_byte = {i_ready, i_cmp_diff, DENSITY_CODE,
                          `SFR_STAT_RSVD};

  wire [7:0] load_byte = (kind_q == `SFR_K_STAT) ? stat_byte : i_rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // next values of the command state

  reg [4:0] state_d;
  reg [6:0] cnt_d;
  reg [23:0] hdr_d;
  reg [2:0] kind_d;
  reg [6:0] hdr_last_d;
  reg [2:0] bitn_d;
  reg [7:0] sh_d;
  reg so_d;
  reg so_oe_d;
  reg [1:0] rd_src_d;
  reg [PAGE_AW-1:0] rd_page_d;
  reg [BYTE_AW-1:0] rd_byte_d;
  reg spi_mode_d;
  reg cmd_active_d;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    kind_d = kind_q;
    hdr_last_d = hdr_last_q;
    bitn_d = bitn_q;
    sh_d = sh_q;
    so_d = o_so;
    so_oe_d = o_so_oe;
    rd_src_d = o_rd_src;
    rd_page_d = o_rd_page;
    rd_byte_d = o_rd_byte;
    spi_mode_d = o_spi_mode;
    cmd_active_d = 1'b1;
    if (cs_s2_q) begin
      // deselect ends whatever was running and floats the output
      state_d = ST_IDLE;
      so_oe_d = 1'b0;
      so_d = 1'b0;
      cmd_active_d = 1'b0;
      cnt_d = 7'h00;
      bitn_d = 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // chip select is low: a fresh command begins
          state_d = ST_OPC;
          cnt_d = 7'h00;
          bitn_d = 3'h0;
          so_oe_d = 1'b0;
          if (sck_rise) begin
            // first bit may already arrive with the select edge
            hdr_d = {hdr_q[22:0], si_s2_q};
            cnt_d = 7'h01;
          end
        end
        ST_OPC: begin
          so_oe_d = 1'b0;
          if (sck_rise) begin
            hdr_d = {hdr_q[22:0], si_s2_q};
            cnt_d = cnt_q + 7'h01;
            if (cnt_q == `SFR_LAST_OP_BIT) begin
              kind_d = kind_now;
              spi_mode_d = op_now[`SFR_OP_CAT_BIT];
              rd_src_d = sfr_src(kind_now);
              hdr_last_d = sfr_hdr_last(kind_now);
              if (kind_now == `SFR_K_STAT) begin
                state_d = ST_DATA;
              end else if (kind_now == `SFR_K_NONE) begin
                state_d = ST_IGN;
              end else begin
                state_d = ST_HDR;
              end
            end
          end
        end
        ST_HDR: begin
          so_oe_d = 1'b0;
          if (sck_rise) begin
            hdr_d = {hdr_q[22:0], si_s2_q};
            cnt_d = cnt_q + 7'h01;
            if (cnt_q == `SFR_LAST_ADDR_BIT) begin
              // buffer_byte_addr lands in the same low nine bits
              rd_page_d = addr_now[`SFR_PAGE_MSB:`SFR_PAGE_LSB];
              rd_byte_d = addr_now[`SFR_BYTE_MSB:`SFR_BYTE_LSB];
            end
            // dummy bits only shift into hdr_q and advance the count
            if (cnt_q == hdr_last_q) begin
              state_d = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // output changes on the falling edge, host samples on the rise
          if (sck_fall) begin
            so_oe_d = 1'b1;
            bitn_d = bitn_q + 3'h1;
            if (bitn_q == 3'h0) begin
              so_d = load_byte[7];
              sh_d = {load_byte[6:0], 1'b0};
              if (kind_q != `SFR_K_STAT) begin
                if (o_rd_byte == LAST_BYTE) begin
                  rd_byte_d = {BYTE_AW{1'b0}};
                  if (kind_q == `SFR_K_CONT) begin
                    // page counter rolls over at the array end
                    rd_page_d = o_rd_page + 1'b1;
                  end
                end else begin
                  rd_byte_d = o_rd_byte + 1'b1;
                end
              end
            end else begin
              so_d = sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_IGN: begin
          // unsupported opcode: stay quiet until deselected
          so_oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          so_oe_d = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register update

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 7'h00;
      hdr_q <= 24'h00_0000;
      kind_q <= `SFR_K_NONE;
      hdr_last_q <= `SFR_LAST_HDR_ARRAY;
      bitn_q <= 3'h0;
      sh_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      kind_q <= kind_d;
      hdr_last_q <= hdr_last_d;
      bitn_q <= bitn_d;
      sh_q <= sh_d;
    end
  end

  // every output port comes straight from one of these flops
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      o_rd_src <= `SFR_SRC_ARRAY;
      o_rd_page <= {PAGE_AW{1'b0}};
      o_rd_byte <= {BYTE_AW{1'b0}};
      o_spi_mode <= 1'b0;
      o_cmd_active <= 1'b0;
    end else begin
      o_so <= so_d;
      o_so_oe <= so_oe_d;
      o_rd_src <= rd_src_d;
      o_rd_page <= rd_page_d;
      o_rd_byte <= rd_byte_d;
      o_spi_mode <= spi_mode_d;
      o_cmd_active <= cmd_active_d;
    end
  end

endmodule

`default_nettype wire

// >>> sfr_read_path_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfr_read_regs.vh"
module sfr_read_path_tb;
  localparam logic [3:0] DENS = 4'h6; // arbitrary value
  logic i_clk, i_rstn, i_ready, i_cmp_diff, oe_seen;
  logic [7:0] i_rd_data;
  logic [63:0] rd;
  wire cs_n, sck, si, so, so_oe, spi_mode, act;
  wire [1:0] src;
  wire [11:0] pg;
  wire [8:0] by;
  // a released line shows the inverse, so an undriven bit cannot pass
  wire so_line = so_oe ? so : ~so;
  int fail_count = 0;
  int checks_done = 0;
  sfr_read_path #(.DENSITY_CODE(DENS)) sfr_read_path_i (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .o_rd_src(src), .o_rd_page(pg), .o_rd_byte(by),
    .i_rd_data(i_rd_data), .i_ready(i_ready), .i_cmp_diff(i_cmp_diff),
    .o_spi_mode(spi_mode), .o_cmd_active(act));
  sfr_host_model sfr_host_model_i (.i_clk(i_clk), .i_so(so_line),
    .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  function automatic logic [7:0] mem(input logic [1:0] s,
      input logic [11:0] p, input logic [8:0] b);
    return b[7:0] ^ {p[3:0] & {4{s == 2'h0}}, b[8], 1'h0, s};
  endfunction
  // storage answers one clock after the address moves
  always @(posedge i_clk) begin
    i_rd_data <= mem(src, pg, by);
    if (so_oe)
      oe_seen <= 1'h1;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_status;
    logic [7:0] op;
    logic [7:0] st;
    for (int k = 0; k < 2; k++) begin
      op = k ? `SFR_OP_STAT_B : `SFR_OP_STAT_A;
      st = {op[7], ~op[7], DENS, 2'h0};
      @(posedge i_clk);
      i_ready <= op[7];
      i_cmp_diff <= ~op[7];
      fork
        sfr_host_model_i.run({op, 56'h0}, 8, 16, rd);
        begin
          // flip readiness inside the first byte, the repeat must see it
          repeat (420) @(posedge i_clk);
          i_ready <= ~op[7];
        end
      join
      check(rd[15:8] & 8'hFC, st);
      check(rd[7:0] & 8'hFC, {~op[7], st[6:0]});
      check(spi_mode, op[7]);
    end
  endtask
  task automatic t_read(input logic [7:0] op, input logic [11:0] p,
      input logic [11:0] p2, input logic [1:0] s);
    logic [63:0] h;
    logic [23:0] e;
    h = s ? {op, 15'h0, 9'h106, 32'h0} : {op, 3'h0, p, 9'h106, 32'h0};
    e = {mem(s, p, 9'h106), mem(s, p, 9'h107), mem(s, p2, 9'h0)};
    sfr_host_model_i.run(h, s ? 40 : 64, 24, rd);
    check(rd[23:0], e);
    check(so_oe, 1'h0);
    check(act, 1'h0);
    check(spi_mode, op[7]);
  endtask
  task automatic t_bad;
    oe_seen <= 1'h0;
    sfr_host_model_i.run({8'h11, 56'h0}, 8, 8, rd);
    check(oe_seen, 1'h0);
    sfr_host_model_i.run({`SFR_OP_CONT_B, 56'h0}, 64, 5, rd);
    check(so_oe, 1'h0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    i_rstn = 1'h0;
    i_ready = 1'h1;
    i_cmp_diff = 1'h0;
    i_rd_data = 8'h0;
    oe_seen = 1'h0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'h1;
    repeat (4) @(posedge i_clk);
    t_status();
    t_read(`SFR_OP_CONT_A, 12'h5, 12'h6, 2'h0);
    t_read(`SFR_OP_CONT_B, 12'hFFF, 12'h0, 2'h0);
    t_read(`SFR_OP_PAGE_A, 12'h7, 12'h7, 2'h0);
    t_read(`SFR_OP_PAGE_B, 12'hFFF, 12'hFFF, 2'h0);
    t_read(`SFR_OP_BUF1_A, 12'h0, 12'h0, 2'h1);
    t_read(`SFR_OP_BUF1_B, 12'h0, 12'h0, 2'h1);
    t_read(`SFR_OP_BUF2_A, 12'h0, 12'h0, 2'h2);
    t_read(`SFR_OP_BUF2_B, 12'h0, 12'h0, 2'h2);
    t_bad();
    finish_test();
  end
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
endmodule
bind sfr_read_path sfr_read_asserts #(.PAGE_BYTES(264)) sfr_read_asserts_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_sck(i_sck),
  .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .o_rd_src(o_rd_src),
  .o_rd_page(o_rd_page), .o_rd_byte(o_rd_byte), .i_rd_data(i_rd_data),
  .i_ready(i_ready), .i_cmp_diff(i_cmp_diff), .o_spi_mode(o_spi_mode),
  .o_cmd_active(o_cmd_active));
`default_nettype wire

// >>> sfr_read_regs.vh
`ifndef SFR_READ_REGS_VH
`define SFR_READ_REGS_VH

// read opcodes, two variants each (low: inactive-polarity, high: spi mode)
`define SFR_OP_CONT_A 8'h68
`define SFR_OP_CONT_B 8'hE8
`define SFR_OP_PAGE_A 8'h52
`define SFR_OP_PAGE_B 8'hD2
`define SFR_OP_BUF1_A 8'h54
`define SFR_OP_BUF1_B 8'hD4
`define SFR_OP_BUF2_A 8'h56
`define SFR_OP_BUF2_B 8'hD6
`define SFR_OP_STAT_A 8'h57
`define SFR_OP_STAT_B 8'hD7

// bit of the opcode that selects the clock category
`define SFR_OP_CAT_BIT 7

// decoded command kinds
`define SFR_K_NONE 3'h0
`define SFR_K_CONT 3'h1
`define SFR_K_PAGE 3'h2
`define SFR_K_BUF1 3'h3
`define SFR_K_BUF2 3'h4
`define SFR_K_STAT 3'h5

// read source select
`define SFR_SRC_ARRAY 2'h0
`define SFR_SRC_BUF1 2'h1
`define SFR_SRC_BUF2 2'h2
`define SFR_SRC_STAT 2'h3

// bit counts of the input phase (count of sck rising edges, minus one)
`define SFR_LAST_OP_BIT 7'h07
`define SFR_LAST_ADDR_BIT 7'h1F
`define SFR_LAST_HDR_ARRAY 7'h3F
`define SFR_LAST_HDR_BUF 7'h27

// field positions in the 24-bit address word
`define SFR_PAGE_MSB 20
`define SFR_PAGE_LSB 9
`define SFR_BYTE_MSB 8
`define SFR_BYTE_LSB 0

// reserved status bits below the density code (bit 2 belongs to the code)
`define SFR_STAT_RSVD 2'h0

`endif
